//--- hw/itf_defines.svh
// Register map, field layout, reset values and filter coefficients
`ifndef ITF_DEFINES_SVH
`define ITF_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------
`define ITF_IDX_TARGET 4'h0
`define ITF_IDX_SETUP 4'h1
`define ITF_IDX_STATUS 4'h2
`define ITF_ADDR_TARGET 6'h00
`define ITF_ADDR_SETUP 6'h04
`define ITF_ADDR_STATUS 6'h08

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ITF_TARGET_MSB 9
`define ITF_FB1_LSB 0
`define ITF_FB2_LSB 2
`define ITF_AVG_BIT 4
`define ITF_BYP_BIT 5
`define ITF_PRE_LSB 6
`define ITF_SETUP_MSB 8
`define ITF_TARGET_RST 16'h0000
`define ITF_SETUP_RST 16'h0000
`define ITF_FULL_SCALE 10'h3FF

// ----------------------------------------------------------------
// One-pole coefficients, Q0.8, at a 100 kHz sample rate
// ----------------------------------------------------------------
`define ITF_FB_A0 8'h27
`define ITF_FB_A1 8'h34
`define ITF_FB_A2 8'h47
`define ITF_FB_A3 8'h65
`define ITF_PRE_A0 8'h0E
`define ITF_PRE_A1 8'h14
`define ITF_PRE_A2 8'h18
`define ITF_PRE_A3 8'h1E
`define ITF_PRE_A4 8'h27
`define ITF_PRE_A5 8'h2F
`define ITF_PRE_A6 8'h39

`endif

//--- hw/itf_pkg.sv
// Shared types of the iris target filter block
package itf_pkg;
   typedef logic [9:0] itf_level_t;
   typedef logic signed [10:0] itf_err_t;
   typedef enum logic [1:0]
   {
      ITF_RESP_OKAY = 2'b00,
      ITF_RESP_SLVERR = 2'b10
   } itf_resp_e;
endpackage

//--- hw/itf_lpf.sv
// One-pole low-pass stage, coefficient chosen by the caller
`timescale 1ns/100ps
module itf_lpf
   import itf_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Coefficient
   input wire logic [7:0] alpha,
   // Sample in
   input wire logic in_valid,
   input wire itf_err_t x,
   // Sample out
   output logic out_valid,
   output itf_err_t y
);
   logic signed [18:0] s_q;
   logic signed [18:0] s_d;
   logic signed [19:0] diff;
   logic signed [28:0] prod;
   logic out_valid_q;

   // State moves by alpha times the remaining distance
   // Sign of a negative error is kept when widened
   assign diff = 20'($signed({x, 8'h00})) - 20'(s_q);
   assign prod = diff * $signed({1'b0, alpha});
   assign s_d = s_q + $signed(prod[26:8]);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q <= 19'h00000;
         out_valid_q <= 1'b0;
      end
      else
      begin
         out_valid_q <= in_valid;
         if (in_valid)
            s_q <= s_d;
      end
   end

   assign out_valid = out_valid_q;
   assign y = s_q[18:8];
endmodule // itf_lpf

//--- hw/itf_mavg.sv
// Moving average of the iris target over four or eight samples
`timescale 1ns/100ps
module itf_mavg
   import itf_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Sample strobe and value
   input wire logic in_valid,
   input wire itf_level_t x,
   input wire logic depth_four,
   // Averaged value
   output itf_level_t avg
);
   itf_level_t tap_q [8];
   logic [12:0] sum8;
   logic [11:0] sum4;
   itf_level_t avg_q;

   genvar i;
   generate
      for (i = 0; i < 8; i++)
      begin : g_tap
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               tap_q[i] <= 10'h000;
            else if (in_valid)
               tap_q[i] <= (i == 0) ? x : tap_q[(i == 0) ? 0 : i - 1];
         end
      end
   endgenerate

   assign sum4 = 12'(tap_q[0]) + 12'(tap_q[1]) + 12'(tap_q[2])
      + 12'(tap_q[3]);
   assign sum8 = 13'(sum4) + 13'(tap_q[4]) + 13'(tap_q[5])
      + 13'(tap_q[6]) + 13'(tap_q[7]);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         avg_q <= 10'h000;
      else
         avg_q <= depth_four ? sum4[11:2] : sum8[12:3];
   end

   assign avg = avg_q;
endmodule // itf_mavg

//--- hw/itf_top.sv
// Iris target and feedback filter front end with AXI4-Lite registers
//
// Notes on behaviour
// RULE_01: Hold 10-bit target n meaning ADC level reference times n/1023.
// RULE_02: Feedback stage one cut-off from 2-bit code: 2600/3600/5200/8000 Hz.
// RULE_03: Feedback stage two has its own code with the same four settings.
// RULE_04: Software normally picks code 0 for both feedback stages.
// RULE_05: Target moving average depth: bit 0 gives 8 values, 1 gives 4.
// RULE_06: Bypass bit 0 inserts the pre-controller low-pass, 1 skips it.
// RULE_07: Software keeps pre-controller filter on unless ringing appears.
// RULE_08: Pre-controller cut-off code 0..6 gives 900 to 4000 Hz; 7 banned.
// RULE_09: Software normally uses code 0 and never writes code 7.
// RULE_10: Error uses averaged target and filtered feedback, per ADC sample.
`timescale 1ns/100ps
`include "itf_defines.svh"
module itf_top
   import itf_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic [2:0] awprot,
   // AXI4-Lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   input wire logic [2:0] arprot,
   // AXI4-Lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // ADC samples from the converter logic
   input wire logic adc_valid,
   input wire itf_level_t adc_sample,
   // Error towards the PID controller
   output logic pid_error_valid,
   output itf_err_t pid_error
);
   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [15:0] target_q;
   logic [15:0] setup_q;

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
   logic awready_q, wready_q, bvalid_q;
   logic aw_take, w_take, wr_fire, wr_target, wr_setup, wr_hit;
   logic [5:0] waddr_q;
   logic [1:0] wstrb_q, bresp_q;
   logic [15:0] wdata_q, wmask, target_wr, setup_wr;

   assign aw_take = awvalid && awready_q;
   assign w_take = wvalid && wready_q;
   assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
   assign aw_hold_d = (aw_hold_q || aw_take) && !wr_fire;
   assign w_hold_d = (w_hold_q || w_take) && !wr_fire;
   assign wr_target = (waddr_q == `ITF_ADDR_TARGET);
   assign wr_setup = (waddr_q == `ITF_ADDR_SETUP);
   assign wr_hit = wr_target || wr_setup;
   assign wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   // RULE_01: ten-bit target
   assign target_wr = ((target_q & ~wmask) | (wdata_q & wmask))
      & {6'h00, `ITF_FULL_SCALE};
   assign setup_wr = ((setup_q & ~wmask) | (wdata_q & wmask))
      & 16'h01FF;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         waddr_q <= 6'h00;
         wdata_q <= 16'h0000;
         wstrb_q <= 2'b00;
      end
      else
      begin
         aw_hold_q <= aw_hold_d;
         w_hold_q <= w_hold_d;
         awready_q <= !aw_hold_d;
         wready_q <= !w_hold_d;
         if (aw_take)
            waddr_q <= {awaddr[5:2], 2'b00};
         if (w_take)
         begin
            wdata_q <= wdata[15:0];
            wstrb_q <= wstrb[1:0];
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= ITF_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? ITF_RESP_OKAY : ITF_RESP_SLVERR;
      end
      else if (bready)
         bvalid_q <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         target_q <= `ITF_TARGET_RST;
         setup_q <= `ITF_SETUP_RST;
      end
      else if (wr_fire)
      begin
         if (wr_target)
            target_q <= target_wr;
         if (wr_setup)
            setup_q <= setup_wr;
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   logic ar_hold_q, ar_hold_d, arready_q, rvalid_q, ar_take, rd_fire;
   logic rd_target, rd_setup, rd_status;
   logic [5:0] raddr_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q, rd_word, status_word;

   assign ar_take = arvalid && arready_q;
   assign rd_fire = ar_hold_q && !rvalid_q;
   assign ar_hold_d = (ar_hold_q || ar_take) && !rd_fire;
   assign rd_target = (raddr_q == `ITF_ADDR_TARGET);
   assign rd_setup = (raddr_q == `ITF_ADDR_SETUP);
   assign rd_status = (raddr_q == `ITF_ADDR_STATUS);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ar_hold_q <= 1'b0;
         arready_q <= 1'b0;
         raddr_q <= 6'h00;
      end
      else
      begin
         ar_hold_q <= ar_hold_d;
         arready_q <= !ar_hold_d;
         if (ar_take)
            raddr_q <= {araddr[5:2], 2'b00};
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= ITF_RESP_OKAY;
      end
      else if (rd_fire)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= (rd_target || rd_setup || rd_status)
            ? ITF_RESP_OKAY : ITF_RESP_SLVERR;
      end
      else if (rready)
         rvalid_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // Filter controls decoded from the setup register
   // ----------------------------------------------------------------
   logic [1:0] fb1_code, fb2_code;
   logic [2:0] pre_code;
   logic avg_four, pre_bypass;
   logic [7:0] fb1_alpha, fb2_alpha, pre_alpha;

   assign fb1_code = setup_q[`ITF_FB1_LSB +: 2];
   assign fb2_code = setup_q[`ITF_FB2_LSB +: 2];
   assign pre_code = setup_q[`ITF_PRE_LSB +: 3];
   assign avg_four = setup_q[`ITF_AVG_BIT];
   assign pre_bypass = setup_q[`ITF_BYP_BIT];

   // RULE_02: stage one cut-off
   assign fb1_alpha = (fb1_code == 2'd0) ? `ITF_FB_A0 :
      (fb1_code == 2'd1) ? `ITF_FB_A1 :
      (fb1_code == 2'd2) ? `ITF_FB_A2 : `ITF_FB_A3;
   // RULE_03: stage two cut-off
   assign fb2_alpha = (fb2_code == 2'd0) ? `ITF_FB_A0 :
      (fb2_code == 2'd1) ? `ITF_FB_A1 :
      (fb2_code == 2'd2) ? `ITF_FB_A2 : `ITF_FB_A3;
   // RULE_08: pre-controller cut-off, banned code held at top setting
   assign pre_alpha = (pre_code == 3'd0) ? `ITF_PRE_A0 :
      (pre_code == 3'd1) ? `ITF_PRE_A1 :
      (pre_code == 3'd2) ? `ITF_PRE_A2 :
      (pre_code == 3'd3) ? `ITF_PRE_A3 :
      (pre_code == 3'd4) ? `ITF_PRE_A4 :
      (pre_code == 3'd5) ? `ITF_PRE_A5 : `ITF_PRE_A6;

   // ----------------------------------------------------------------
   // Signal path
   // ----------------------------------------------------------------
   itf_level_t avg_target;
   logic fb1_valid, fb2_valid, err_valid_q, pre_valid, pid_valid_q;
   itf_err_t fb1_y, fb2_y, err_q, pre_y, pid_error_q;

   // RULE_05: target average per ADC sample
   itf_mavg u_mavg
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(adc_valid),
      .x(target_q[`ITF_TARGET_MSB:0]),
      .depth_four(avg_four),
      .avg(avg_target)
   );

   itf_lpf u_fb1
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .alpha(fb1_alpha),
      .in_valid(adc_valid),
      .x({1'b0, adc_sample}),
      .out_valid(fb1_valid),
      .y(fb1_y)
   );

   itf_lpf u_fb2
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .alpha(fb2_alpha),
      .in_valid(fb1_valid),
      .x(fb1_y),
      .out_valid(fb2_valid),
      .y(fb2_y)
   );

   // RULE_10: error from averaged target and filtered feedback
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         err_valid_q <= 1'b0;
         err_q <= 11'h000;
      end
      else
      begin
         err_valid_q <= fb2_valid;
         if (fb2_valid)
            err_q <= $signed({1'b0, avg_target}) - fb2_y;
      end
   end

   itf_lpf u_pre
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .alpha(pre_alpha),
      .in_valid(err_valid_q),
      .x(err_q),
      .out_valid(pre_valid),
      .y(pre_y)
   );

   // RULE_06: bypass selects raw or filtered error
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pid_valid_q <= 1'b0;
         pid_error_q <= 11'h000;
      end
      else
      begin
         pid_valid_q <= pre_valid;
         if (pre_valid)
            pid_error_q <= pre_bypass ? err_q : pre_y;
      end
   end

   // ----------------------------------------------------------------
   // Read data selection
   // ----------------------------------------------------------------
   assign status_word = {6'h00, avg_target, 5'h00, fb2_y};
   assign rd_word = rd_target ? {16'h0000, target_q} :
      rd_setup ? {16'h0000, setup_q} :
      rd_status ? status_word : 32'h00000000;

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign pid_error_valid = pid_valid_q;
   assign pid_error = pid_error_q;
endmodule // itf_top

//--- testbench/itf_top_props.sv
// Assertion checker for the iris target filter top level
`timescale 1ns/100ps
module itf_top_props
   import itf_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   // Sample path
   input wire logic adc_valid,
   input wire logic pid_error_valid,
   input wire itf_err_t pid_error
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_aw_closes: assert property (awvalid && awready |=> !awready)
      else $error("awready high after address take");
   a_b_answers: assert property
      (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
      else $error("write response missing");
   a_b_single: assert property (bvalid && bready |=> !bvalid)
      else $error("bvalid high after response taken");
   a_ar_closes: assert property (arvalid && arready |=> !arready)
      else $error("arready high after address take");
   a_r_answers: assert property
      (arvalid && arready |-> ##[1:3] rvalid)
      else $error("read data missing");
   a_r_unmapped: assert property
      (rvalid && rresp == 2'b10 |-> rdata == 32'h0)
      else $error("refused read returns data");
   a_pid_answers: assert property
      (adc_valid |-> ##[4:7] pid_error_valid)
      else $error("no error output after sample");
   a_pid_cause: assert property (pid_error_valid |->
      $past(adc_valid, 5) || $past(adc_valid, 6))
      else $error("error output without sample");
   a_pid_stands: assert property
      (!pid_error_valid && $past(aresetn) |-> $stable(pid_error))
      else $error("error changed between samples");

   c_write: cover property (awvalid && awready && wvalid && wready);
   c_read: cover property (arvalid && arready);
   c_error: cover property (pid_error_valid);
endmodule // itf_top_props

bind itf_top itf_top_props props_u
(
   .aclk(aclk),
   .aresetn(aresetn),
   .awvalid(awvalid),
   .awready(awready),
   .wvalid(wvalid),
   .wready(wready),
   .bvalid(bvalid),
   .bready(bready),
   .arvalid(arvalid),
   .arready(arready),
   .rvalid(rvalid),
   .rdata(rdata),
   .rresp(rresp),
   .adc_valid(adc_valid),
   .pid_error_valid(pid_error_valid),
   .pid_error(pid_error)
);

//--- testbench/itf_top_tb.sv
// Self-checking testbench for the iris target filter front end
`timescale 1ns/100ps
`include "itf_defines.svh"
module itf_top_tb;
   import itf_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus and model state
   // ----------------------------------------------------------------
   logic aclk = 0;
   logic aresetn = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata;
   logic [3:0] wstrb = 0;
   logic awready, wready, bvalid, arready, rvalid, pid_error_valid;
   logic [1:0] bresp, rresp, rs;
   logic adc_valid = 0;
   itf_level_t adc_sample = 0;
   itf_err_t pid_error, er;
   itf_err_t e[$];
   int hist[$] = '{0, 0, 0, 0, 0, 0, 0, 0};
   int failures = 0, comparisons = 0, cycles = 0;
   logic [31:0] seed = 95;
   logic [31:0] tbl[17] = '{32'h2C, 32'h2D, 32'h2E, 32'h2F, 32'h23,
      32'h27, 32'h2B, 32'h2F, 32'h0F, 32'h4F, 32'h8F, 32'hCF, 32'h10F,
      32'h14F, 32'h18F, 32'h18F, 32'h2F};

   always #5 aclk = ~aclk;

   itf_top dut_u
   (
      .aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .adc_valid(adc_valid), .adc_sample(adc_sample),
      .pid_error_valid(pid_error_valid), .pid_error(pid_error)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic check(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic rst(input int k);
      aresetn <= 0;
      repeat (k) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      hist = '{0, 0, 0, 0, 0, 0, 0, 0};
   endtask

   task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
      awvalid <= 1;
      awaddr <= a;
      wvalid <= 1;
      wdata <= d;
      wstrb <= 4'hF;
      bready <= 1;
      fork
         begin
            do @(posedge aclk); while (awready !== 1'b1);
            awvalid <= 0;
         end
         begin
            do @(posedge aclk); while (wready !== 1'b1);
            wvalid <= 0;
         end
      join
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [31:0] a, output logic [31:0] d,
      output logic [1:0] r);
      arvalid <= 1;
      araddr <= a;
      rready <= 1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 0;
      @(posedge aclk);
   endtask

   // One sample, then the error it produces
   task automatic smp(input itf_level_t s, output itf_err_t v);
      adc_valid <= 1;
      adc_sample <= s;
      @(posedge aclk);
      adc_valid <= 0;
      adc_sample <= itf_level_t'(xs());
      do @(posedge aclk); while (pid_error_valid !== 1'b1);
      v = pid_error;
   endtask

   task automatic step(input itf_level_t t, input int dep);
      int s;
      s = 0;
      wr(32'(`ITF_ADDR_TARGET), 32'(t), rs);
      hist.push_front(int'(t));
      for (int i = 0; i < dep; i++)
         s += hist[i];
      smp(10'h0, er);
      if (s % dep == 0)
         check(32'(er), 32'(s / dep));
   endtask

   task automatic run(input logic [31:0] su, output itf_err_t v);
      rst(2);
      wr(32'(`ITF_ADDR_SETUP), su, rs);
      repeat (3) smp(10'h3FF, v);
   endtask

   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         failures++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] a, d;
      rst(20);
      for (int i = 0; i < 3; i++)
      begin
         a = 32'(i == 2 ? 12 : i * 4);
         rd(a, d, rs);
         check(d, 32'h0);
         wr(a, i == 1 ? 32'hFFFFFFBF : 32'hFFFFFFFF, rs);
         check(32'(rs), i == 2 ? 32'h2 : 32'h0);
         rd(a, d, rs);
         check(d, i == 0 ? 32'h3FF : i == 1 ? 32'h1BF : 32'h0);
         check(32'(rs), i == 2 ? 32'h2 : 32'h0);
      end
      wr(32'(`ITF_ADDR_STATUS), 32'hFFFFFFFF, rs);
      check(32'(rs), 32'h2);
      $display("register test done");
      for (int k = 0; k < 2; k++)
      begin
         wr(32'(`ITF_ADDR_SETUP), 32'h20 | 32'(k << 4), rs);
         for (int j = 0; j < 12; j++)
            step(10'((xs() & 32'h7F) << 3), k ? 4 : 8);
      end
      wr(32'(`ITF_ADDR_SETUP), 32'h20, rs);
      repeat (8) step(10'h3FF, 8);
      rd(32'(`ITF_ADDR_STATUS), d, rs);
      check(32'(d[25:16]), 32'h3FF);
      $display("average test done");
      for (int i = 0; i < 17; i++)
      begin
         run(tbl[i], er);
         e.push_back(er);
         if (i == 15)
            check(32'(er), 32'(e[14]));
         else if (i == 16)
            check(32'(er < e[15]), 32'h1);
         else if (i != 0 && i != 4 && i != 8)
            check(32'(er < e[i - 1]), 32'h1);
      end
      $display("cut-off test done");
      end_of_test();
   end
endmodule // itf_top_tb
